// ==== shared/serial_port_pkg.sv ====
// Register map, field positions, reset values and rate constants of the serial port
package serial_port_pkg;

  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned ADDR_W       = 8;

  // Byte offsets of the registers on the bus
  localparam logic [7:0]  TSC_OFF      = 8'h00;
  localparam logic [7:0]  RSC_OFF      = 8'h04;
  localparam logic [7:0]  BRC_OFF      = 8'h08;
  localparam logic [7:0]  DIVL_OFF     = 8'h0C;
  localparam logic [7:0]  DIVH_OFF     = 8'h10;

  // transmit_status_control fields
  localparam int unsigned CLOCK_SOURCE_SELECT_B       = 7;
  localparam int unsigned TX9_B        = 6;
  localparam int unsigned TRANSMIT_ENABLE_BIT_B       = 5;
  localparam int unsigned SYNC_B       = 4;
  localparam int unsigned BREAK_REQUEST_B      = 3;
  localparam int unsigned HIGH_SPEED_SELECT_B       = 2;
  localparam int unsigned TRANSMIT_SHIFT_EMPTY_B       = 1;
  localparam int unsigned TRANSMIT_NINTH_BIT_B       = 0;
  localparam logic [7:0]  TSC_RST      = 8'h02;
  localparam logic [7:0]  TSC_WMASK    = 8'hFD;

  // receive_status_control fields
  localparam int unsigned PORT_ENABLE_B       = 7;
  localparam int unsigned RX9_B        = 6;
  localparam int unsigned SINGLE_RECEIVE_ENABLE_B       = 5;
  localparam int unsigned CONTINUOUS_RECEIVE_ENABLE_B       = 4;
  localparam int unsigned ADDRESS_DETECT_ENABLE_B      = 3;
  localparam int unsigned FRAMING_ERROR_FLAG_B       = 2;
  localparam int unsigned OVERRUN_ERROR_FLAG_B       = 1;
  localparam int unsigned RECEIVE_NINTH_BIT_B       = 0;
  localparam logic [7:0]  RSC_RST      = 8'h00;
  localparam logic [7:0]  RSC_WMASK    = 8'hF8;

  // baud_rate_control fields
  localparam int unsigned AUTOBAUD_ROLLOVER_FLAG_B     = 7;
  localparam int unsigned RECEIVE_IDLE_STATUS_B      = 6;
  localparam int unsigned RECEIVE_POLARITY_SELECT_B      = 5;
  localparam int unsigned TRANSMIT_CLOCK_POLARITY_SELECT_B      = 4;
  localparam int unsigned WIDE_DIVISOR_SELECT_B      = 3;
  localparam int unsigned WUE_B        = 1;
  localparam int unsigned AUTOBAUD_ENABLE_B      = 0;
  localparam logic [7:0]  BRC_RST      = 8'h40;
  localparam logic [7:0]  BRC_WMASK    = 8'hBB;

  localparam logic [7:0]  DIV_RST      = 8'h00;

  // Prescaler terminal counts: clock divided by 64, 16 or 4 before the divisor
  localparam logic [5:0]  PRESC_64     = 6'h3F;
  localparam logic [5:0]  PRESC_16     = 6'h0F;
  localparam logic [5:0]  PRESC_4      = 6'h03;

  // Rate measurement spans eight bit times of the 55h sync field
  localparam int unsigned AB_CNT_W     = 19;
  localparam int unsigned AB_SHIFT     = 3;
  localparam logic [2:0]  AB_LAST_EDGE = 3'h4;

endpackage

// ==== hdl/serial_port_ctrl.sv ====
// Serial port control, status, pin sampling, wake-up, rate measurement and baud generator
//
// Contract
// - Synchronous: clock source bit 1 = master drives clock, 0 = slave takes pin clock.
// - Nine-bit transmit select picks 9- or 8-bit frames; separate transmit enable bit.
// - Mode bit 1 selects synchronous operation, 0 asynchronous.
// - Async break request sends break next; hardware clears it when break is sent.
// - High-speed select matters only in async; divisor sets free-running timer period.
// - Transmit shift empty bit reads 1 when shift register empty; resets to 1.
// - Synchronous: continuous receive, or single receive in master mode, overrides transmit enable.
// - Port enable claims the pins; while 0 the port is held in reset.
// - Sync master single receive takes one character, cleared on completion.
// - Continuous receive enables receiver; in sync it overrides single receive.
// - Async 9-bit with address detect loads only characters whose bit 8 is 1.
// - Framing error flag reports bad stop bit, updated on next received character.
// - Overrun flag sets on lost data; cleared by clearing continuous receive.
// - Rate measurement rollover sets a flag; only software clears it.
// - Receive idle bit reads 0 during reception, 1 otherwise; resets to 1.
// - Async receive polarity bit inverts incoming data.
// - Polarity bit: async transmit idle low when 1; sync clock idle high when 1.
// - Wide divisor bit uses both divisor bytes; otherwise high byte ignored.
// - Async wake-up: falling receive edge signals, next rising edge clears enable.
// - Rate measurement on next 55h character, enable cleared when done; async only.
// - Writing either divisor byte restarts the baud generator at once.
// - Three-sample majority, single sample in sync or high-speed 16-bit mode.
// - Async 8-bit low speed: rate is clock over 64 times divisor plus one.
`timescale 1ns/10ps

module serial_port_ctrl
  import serial_port_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  input  wire logic                 tx_ck_i,
  output logic                      tx_ck_o,
  output logic                      tx_ck_oe_n,
  input  wire logic                 rx_dt_i,
  output logic                      rx_dt_o,
  output logic                      rx_dt_oe_n,
  input  wire logic                 tx_line,
  input  wire logic                 sync_dt_bit,
  input  wire logic                 shift_loaded,
  input  wire logic                 shift_done,
  input  wire logic                 break_sent,
  input  wire logic                 rx_start,
  input  wire logic                 rx_done,
  input  wire logic                 rx_bit8,
  input  wire logic                 rx_stop_ok,
  input  wire logic                 rx_lost,
  output logic                      port_active,
  output logic                      baud_tick,
  output logic                      sync_mode,
  output logic                      master_mode,
  output logic                      tx_nine_bit,
  output logic                      transmit_ninth_bit,
  output logic                      rx_nine_bit,
  output logic                      tx_active,
  output logic                      rx_active,
  output logic                      break_pending,
  output logic                      rx_data_level,
  output logic                      slave_clk_level,
  output logic                      rx_accept,
  output logic                      wake_event
);
  import serial_port_pkg::*;

  typedef enum logic [1:0] {AB_FALL, AB_RISE, AB_COUNT} ab_state_e;

  typedef struct packed {
    logic [7:0]          tsc;
    logic [7:0]          rsc;
    logic [7:0]          brc;
    logic [7:0]          div_lo;
    logic [7:0]          div_hi;
    logic [ADDR_W-1:0]   wr_addr;
    logic                wr_pend;
    logic [31:0]         rdata;
    logic                rx_s1;
    logic                rx_s2;
    logic                rx_s3;
    logic                ck_s1;
    logic                ck_s2;
    logic                ck_s3;
    logic                rx_stable;
    logic [2:0]          rx_hist;
    logic                rx_level;
    logic                rx_level_d;
    logic                ck_level;
    logic [5:0]          presc;
    logic [15:0]         baud_generator;
    logic                tick;
    logic                ck_phase;
    ab_state_e           ab_state;
    logic [AB_CNT_W-1:0] ab_cnt;
    logic [2:0]          ab_edges;
    logic                wake;
    logic                tx_ck_o;
    logic                tx_ck_oe_n;
    logic                dt_o;
    logic                dt_oe_n;
  } state_s;

  state_s state_r;
  state_s state_nxt;

  // Maps a bus offset to a register number, 0 for an unmapped offset
  function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] a);
    case (a)
      TSC_OFF:  reg_index = 3'h1;
      RSC_OFF:  reg_index = 3'h2;
      BRC_OFF:  reg_index = 3'h3;
      DIVL_OFF: reg_index = 3'h4;
      DIVH_OFF: reg_index = 3'h5;
      default:  reg_index = 3'h0;
    endcase
  endfunction

  logic        is_sync;
  logic        is_master;
  logic        wide;
  logic        rx_en_eff;
  logic        tx_en_eff;
  logic [5:0]  presc_max;
  logic [15:0] div_val;
  logic        presc_wrap;
  logic        accept;
  logic        addr_valid;
  logic        rise;
  logic        fall;
  logic        maj;
  logic        single;
  logic [15:0] ab_result;

  always_comb
  begin
    state_nxt  = state_r;
    is_sync    = state_r.tsc[SYNC_B];
    is_master  = is_sync & state_r.tsc[CLOCK_SOURCE_SELECT_B];
    wide       = state_r.brc[WIDE_DIVISOR_SELECT_B];
    rx_en_eff  = state_r.rsc[CONTINUOUS_RECEIVE_ENABLE_B] | (is_master & state_r.rsc[SINGLE_RECEIVE_ENABLE_B]);
    tx_en_eff  = state_r.tsc[TRANSMIT_ENABLE_BIT_B] & ~(is_sync & rx_en_eff);
    div_val    = wide ? {state_r.div_hi, state_r.div_lo} : {8'h00, state_r.div_lo};
    // Divisor prescale by mode; high-speed bit only counts in async
    if (!is_sync && !wide && !state_r.tsc[HIGH_SPEED_SELECT_B])
    begin
      presc_max = PRESC_64;
    end
    else if (!is_sync && (wide ^ state_r.tsc[HIGH_SPEED_SELECT_B]))
    begin
      presc_max = PRESC_16;
    end
    else
    begin
      presc_max = PRESC_4;
    end
    presc_wrap = state_r.presc == presc_max;
    accept     = rx_done & ~(~is_sync & state_r.rsc[RX9_B] &
                             state_r.rsc[ADDRESS_DETECT_ENABLE_B] & ~rx_bit8);
    addr_valid = hsel & htrans[1] & hready;
    rise       = state_r.rx_level & ~state_r.rx_level_d;
    fall       = ~state_r.rx_level & state_r.rx_level_d;
    maj        = (state_r.rx_hist[0] & state_r.rx_hist[1]) |
                 (state_r.rx_hist[1] & state_r.rx_hist[2]) |
                 (state_r.rx_hist[0] & state_r.rx_hist[2]);
    single     = is_sync | (wide & state_r.tsc[HIGH_SPEED_SELECT_B]);
    ab_result  = 16'(state_r.ab_cnt >> AB_SHIFT) - 16'h0001;

    // Pin synchronisers: a new level counts once the second and third stages agree
    state_nxt.rx_s1 = rx_dt_i;
    state_nxt.rx_s2 = state_r.rx_s1;
    state_nxt.rx_s3 = state_r.rx_s2;
    state_nxt.ck_s1 = tx_ck_i;
    state_nxt.ck_s2 = state_r.ck_s1;
    state_nxt.ck_s3 = state_r.ck_s2;
    if (state_r.rx_s2 == state_r.rx_s3)
    begin
      state_nxt.rx_stable = state_r.rx_s3;
    end
    if (state_r.ck_s2 == state_r.ck_s3)
    begin
      state_nxt.ck_level = state_r.ck_s3;
    end
    state_nxt.rx_hist    = {state_r.rx_hist[1:0], state_r.rx_stable};
    state_nxt.rx_level   = (single ? state_r.rx_stable : maj) ^
                           (~is_sync & state_r.brc[RECEIVE_POLARITY_SELECT_B]);
    state_nxt.rx_level_d = state_r.rx_level;

    // Bus: address phase captured, write lands in the data phase, read data registered early
    state_nxt.wr_pend = addr_valid & hwrite;
    if (addr_valid)
    begin
      state_nxt.wr_addr = haddr[ADDR_W-1:0];
      case (reg_index(haddr[ADDR_W-1:0]))
        3'h1:    state_nxt.rdata = {24'h000000, state_r.tsc};
        3'h2:    state_nxt.rdata = {24'h000000, state_r.rsc};
        3'h3:    state_nxt.rdata = {24'h000000, state_r.brc};
        3'h4:    state_nxt.rdata = {24'h000000, state_r.div_lo};
        3'h5:    state_nxt.rdata = {24'h000000, state_r.div_hi};
        default: state_nxt.rdata = 32'h00000000;
      endcase
    end

    // Baud generator: prescaler then divisor down-counter
    state_nxt.tick = 1'b0;
    if (presc_wrap)
    begin
      state_nxt.presc = 6'h00;
      if (state_r.baud_generator == 16'h0000)
      begin
        state_nxt.baud_generator  = div_val;
        state_nxt.tick = 1'b1;
      end
      else
      begin
        state_nxt.baud_generator = state_r.baud_generator - 16'h0001;
      end
    end
    else
    begin
      state_nxt.presc = state_r.presc + 6'h01;
    end

    if (state_r.wr_pend)
    begin
      case (reg_index(state_r.wr_addr))
        3'h1:
        begin
          state_nxt.tsc = (hwdata[7:0] & TSC_WMASK) | (state_r.tsc & ~TSC_WMASK);
        end
        3'h2:
        begin
          state_nxt.rsc = (hwdata[7:0] & RSC_WMASK) | (state_r.rsc & ~RSC_WMASK);
        end
        3'h3:
        begin
          state_nxt.brc = (hwdata[7:0] & BRC_WMASK) | (state_r.brc & ~BRC_WMASK);
        end
        3'h4, 3'h5:
        begin
          if (reg_index(state_r.wr_addr) == 3'h4)
          begin
            state_nxt.div_lo = hwdata[7:0];
          end
          else
          begin
            state_nxt.div_hi = hwdata[7:0];
          end
          state_nxt.presc = 6'h00;
          state_nxt.baud_generator   = 16'h0000;
          state_nxt.tick  = 1'b0;
        end
        default:
        begin
          state_nxt.rdata = state_r.rdata;
        end
      endcase
    end

    // Hardware updates follow the software write so that a hardware update wins over a write in the same cycle
    state_nxt.wake = 1'b0;
    if (shift_loaded)
    begin
      state_nxt.tsc[TRANSMIT_SHIFT_EMPTY_B] = 1'b0;
    end
    if (shift_done)
    begin
      state_nxt.tsc[TRANSMIT_SHIFT_EMPTY_B] = 1'b1;
    end
    if (break_sent && !is_sync)
    begin
      state_nxt.tsc[BREAK_REQUEST_B] = 1'b0;
    end
    if (rx_start)
    begin
      state_nxt.brc[RECEIVE_IDLE_STATUS_B] = 1'b0;
    end
    if (rx_done)
    begin
      state_nxt.brc[RECEIVE_IDLE_STATUS_B] = 1'b1;
      if (is_master && !state_r.rsc[CONTINUOUS_RECEIVE_ENABLE_B])
      begin
        state_nxt.rsc[SINGLE_RECEIVE_ENABLE_B] = 1'b0;
      end
    end
    if (accept)
    begin
      state_nxt.rsc[RECEIVE_NINTH_BIT_B] = rx_bit8;
      state_nxt.rsc[FRAMING_ERROR_FLAG_B] = ~rx_stop_ok;
    end
    if (!state_nxt.rsc[CONTINUOUS_RECEIVE_ENABLE_B])
    begin
      state_nxt.rsc[OVERRUN_ERROR_FLAG_B] = 1'b0;
    end
    if (rx_lost)
    begin
      state_nxt.rsc[OVERRUN_ERROR_FLAG_B] = 1'b1;
    end

    // Wake-up watch on the receive line
    if (!is_sync && state_r.brc[WUE_B])
    begin
      if (fall)
      begin
        state_nxt.wake = 1'b1;
      end
      if (rise)
      begin
        state_nxt.brc[WUE_B] = 1'b0;
      end
    end

    // Rate measurement: first rising edge of 55h to the fifth spans eight bits
    if (is_sync || !state_r.brc[AUTOBAUD_ENABLE_B])
    begin
      state_nxt.ab_state = AB_FALL;
    end
    else
    begin
      case (state_r.ab_state)
        AB_FALL:
        begin
          if (fall)
          begin
            state_nxt.ab_state = AB_RISE;
          end
        end
        AB_RISE:
        begin
          if (rise)
          begin
            state_nxt.ab_state = AB_COUNT;
            state_nxt.ab_cnt   = '0;
            state_nxt.ab_edges = 3'h0;
          end
        end
        AB_COUNT:
        begin
          if (presc_wrap)
          begin
            state_nxt.ab_cnt = state_r.ab_cnt + AB_CNT_W'(1);
          end
          if (rise)
          begin
            state_nxt.ab_edges = state_r.ab_edges + 3'h1;
          end
          if (&state_r.ab_cnt)
          begin
            state_nxt.brc[AUTOBAUD_ROLLOVER_FLAG_B] = 1'b1;
            state_nxt.brc[AUTOBAUD_ENABLE_B]  = 1'b0;
            state_nxt.ab_state      = AB_FALL;
          end
          else if (rise && state_r.ab_edges == AB_LAST_EDGE - 3'h1)
          begin
            state_nxt.div_lo        = ab_result[7:0];
            state_nxt.div_hi        = ab_result[15:8];
            state_nxt.brc[AUTOBAUD_ENABLE_B]  = 1'b0;
            state_nxt.ab_state      = AB_FALL;
            state_nxt.presc         = 6'h00;
            state_nxt.baud_generator           = 16'h0000;
          end
        end
        default:
        begin
          state_nxt.ab_state = AB_FALL;
        end
      endcase
    end

    // Master clock toggles on each baud tick while a transfer is enabled
    if (is_master && (tx_en_eff || rx_en_eff))
    begin
      if (state_r.tick)
      begin
        state_nxt.ck_phase = ~state_r.ck_phase;
      end
    end
    else
    begin
      state_nxt.ck_phase = 1'b0;
    end

    // Pin drivers; enables are low while the pin is driven
    if (!state_r.rsc[PORT_ENABLE_B])
    begin
      state_nxt.tx_ck_oe_n = 1'b1;
      state_nxt.dt_oe_n    = 1'b1;
    end
    else if (!is_sync)
    begin
      state_nxt.tx_ck_o    = tx_line ^ state_r.brc[TRANSMIT_CLOCK_POLARITY_SELECT_B];
      state_nxt.tx_ck_oe_n = 1'b0;
      state_nxt.dt_oe_n    = 1'b1;
    end
    else
    begin
      state_nxt.tx_ck_o    = state_r.ck_phase ^ state_r.brc[TRANSMIT_CLOCK_POLARITY_SELECT_B];
      state_nxt.tx_ck_oe_n = ~is_master;
      state_nxt.dt_o       = sync_dt_bit;
      state_nxt.dt_oe_n    = ~tx_en_eff;
    end

    // A disabled port keeps control bits but resets error, idle and shift-empty flags, baud generator, rate measurement, master clock and wake pulse
    if (!state_r.rsc[PORT_ENABLE_B])
    begin
      state_nxt.tsc[TRANSMIT_SHIFT_EMPTY_B]   = 1'b1;
      state_nxt.rsc[FRAMING_ERROR_FLAG_B]   = 1'b0;
      state_nxt.rsc[OVERRUN_ERROR_FLAG_B]   = 1'b0;
      state_nxt.brc[RECEIVE_IDLE_STATUS_B]  = 1'b1;
      state_nxt.presc         = 6'h00;
      state_nxt.baud_generator           = 16'h0000;
      state_nxt.tick          = 1'b0;
      state_nxt.ab_state      = AB_FALL;
      state_nxt.ck_phase      = 1'b0;
      state_nxt.wake          = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r            <= '0;
      state_r.tsc        <= TSC_RST;
      state_r.rsc        <= RSC_RST;
      state_r.brc        <= BRC_RST;
      state_r.div_lo     <= DIV_RST;
      state_r.div_hi     <= DIV_RST;
      state_r.rx_s1      <= 1'b1;
      state_r.rx_s2      <= 1'b1;
      state_r.rx_s3      <= 1'b1;
      state_r.rx_stable  <= 1'b1;
      state_r.rx_hist    <= 3'h7;
      state_r.rx_level   <= 1'b1;
      state_r.rx_level_d <= 1'b1;
      state_r.ab_state   <= AB_FALL;
      state_r.tx_ck_o    <= 1'b1;
      state_r.tx_ck_oe_n <= 1'b1;
      state_r.dt_oe_n    <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign hreadyout          = 1'b1;
  assign hresp              = 1'b0;
  assign hrdata             = state_r.rdata;
  assign tx_ck_o            = state_r.tx_ck_o;
  assign tx_ck_oe_n         = state_r.tx_ck_oe_n;
  assign rx_dt_o            = state_r.dt_o;
  assign rx_dt_oe_n         = state_r.dt_oe_n;
  assign port_active        = state_r.rsc[PORT_ENABLE_B];
  assign baud_tick          = state_r.tick;
  assign sync_mode          = is_sync;
  assign master_mode        = is_master;
  assign tx_nine_bit        = state_r.tsc[TX9_B];
  assign transmit_ninth_bit = state_r.tsc[TRANSMIT_NINTH_BIT_B];
  assign rx_nine_bit        = state_r.rsc[RX9_B];
  assign tx_active          = state_r.rsc[PORT_ENABLE_B] & tx_en_eff;
  assign rx_active          = state_r.rsc[PORT_ENABLE_B] & rx_en_eff;
  assign break_pending      = ~is_sync & state_r.tsc[BREAK_REQUEST_B];
  assign rx_data_level      = state_r.rx_level;
  assign slave_clk_level    = state_r.ck_level;
  assign rx_accept          = state_r.rsc[PORT_ENABLE_B] & accept;
  assign wake_event         = state_r.wake;

endmodule // serial_port_ctrl

// ==== tb/remote_node.sv ====
// Remote serial node driving the asynchronous receive line of the port
`timescale 1ns/10ps

module remote_node (
  input  wire logic clk,
  output logic      line
);
  // The line starts at the mark level and each frame ends on it, so between frames it rests there
  initial line = 1'b1;

  // One frame: start bit, eight data bits least significant first, stop bit
  task automatic send(input logic [7:0] b, input int bt);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      line <= f[i];
      repeat (bt) @(posedge clk);
    end
  endtask
endmodule  // remote_node

// ==== tb/serial_port_ctrl_sva.sv ====
// Port-level assertions for the serial port control block
`timescale 1ns/10ps

module serial_port_ctrl_sva
  import serial_port_pkg::*;
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        rx_dt_i,
  input wire logic        rx_done,
  input wire logic        tx_ck_oe_n,
  input wire logic        rx_dt_oe_n,
  input wire logic        port_active,
  input wire logic        baud_tick,
  input wire logic        sync_mode,
  input wire logic        rx_nine_bit,
  input wire logic        tx_active,
  input wire logic        rx_active,
  input wire logic        break_pending,
  input wire logic        rx_data_level,
  input wire logic        rx_accept,
  input wire logic        wake_event
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  pins_released_a: assert property (!port_active && !$past(port_active) |-> tx_ck_oe_n && rx_dt_oe_n)
    else $error("Pins driven while port disabled");
  rx_over_tx_a: assert property (sync_mode && rx_active |-> !tx_active)
    else $error("Transmit active while sync receive enabled");
  rx_needs_port_a: assert property (rx_active |-> port_active)
    else $error("Receiver active with port disabled");
  break_async_a: assert property (break_pending |-> !sync_mode)
    else $error("Break pending in synchronous mode");
  tick_pulse_a: assert property (baud_tick |=> !baud_tick)
    else $error("Baud tick longer than one cycle");
  div_restart_a: assert property (hsel && htrans[1] && hready && hwrite &&
    (haddr[7:0] == DIVL_OFF || haddr[7:0] == DIVH_OFF) |=> ##2 !baud_tick [*2])
    else $error("Baud tick too soon after divisor write");
  accept_gate_a: assert property (rx_accept |-> rx_done && port_active)
    else $error("Character accepted without completion");
  plain_accept_a: assert property (rx_done && port_active && !rx_nine_bit |-> rx_accept)
    else $error("Eight-bit character not accepted");
  wake_async_a: assert property (wake_event |-> !sync_mode ##1 !wake_event)
    else $error("Wake event in sync mode or held");
  rx_level_a: assert property ((port_active && sync_mode && $stable(rx_dt_i)) [*8]
    |-> rx_data_level == rx_dt_i)
    else $error("Sampled receive level wrong");
endmodule  // serial_port_ctrl_sva

bind serial_port_ctrl serial_port_ctrl_sva u_sva (.clk, .rstn, .hsel, .haddr, .htrans, .hwrite,
  .hready, .rx_dt_i, .rx_done, .tx_ck_oe_n, .rx_dt_oe_n, .port_active, .baud_tick, .sync_mode,
  .rx_nine_bit, .tx_active, .rx_active, .break_pending, .rx_data_level, .rx_accept, .wake_event);

// ==== tb/serial_port_ctrl_tb.sv ====
// Self-checking bench for the serial port control block
`timescale 1ns/10ps

module serial_port_ctrl_tb;
  import serial_port_pkg::*;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [5:0]  dp = 6'h00;
  logic        bit8 = 1'b0;
  logic        stop_ok = 1'b1;
  logic [15:0] lf = 16'd16113;
  logic [31:0] hrdata;
  logic        hreadyout, tx_ck_o, tx_ck_oe_n, rx_dt_o, rx_dt_oe_n, line;
  logic        rx_accept, wake_event, baud_tick;
  logic [7:0]  q;
  logic [7:0]  offs [6] = '{TSC_OFF, BRC_OFF, DIVL_OFF, DIVH_OFF, 8'h14, RSC_OFF};
  logic [7:0]  tv [6] = '{8'h00, 8'h04, 8'h00, 8'h04, 8'h90, 8'h94};
  logic [7:0]  bv [6] = '{8'h00, 8'h00, 8'h08, 8'h08, 8'h00, 8'h00};
  int          per [6] = '{192, 48, 4144, 1036, 12, 12};
  int          err_total = 0;
  int          num_checks = 0;
  int          dur;

  always #25 clk = ~clk;

  remote_node u_node (.clk, .line);

  serial_port_ctrl u_dut (
    .clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata, .hready(hreadyout),
    .hreadyout, .hresp(), .hrdata, .tx_ck_i(tx_ck_oe_n ? 1'b1 : tx_ck_o), .tx_ck_o, .tx_ck_oe_n,
    .rx_dt_i(rx_dt_oe_n ? line : rx_dt_o), .rx_dt_o, .rx_dt_oe_n, .tx_line(lf[3]),
    .sync_dt_bit(lf[7]), .shift_loaded(dp[0]), .shift_done(dp[1]), .break_sent(dp[2]),
    .rx_start(dp[3]), .rx_done(dp[4]), .rx_bit8(bit8), .rx_stop_ok(stop_ok), .rx_lost(dp[5]),
    .port_active(), .baud_tick, .sync_mode(), .master_mode(), .tx_nine_bit(),
    .transmit_ninth_bit(), .rx_nine_bit(), .tx_active(), .rx_active(), .break_pending(),
    .rx_data_level(), .slave_clk_level(), .rx_accept, .wake_event);

  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Read-back of a written value; read-only bits keep their idle state
  function automatic logic [7:0] rb(input logic [7:0] a, input logic [7:0] w);
    case (a)
      TSC_OFF: return (w & 8'hFD) | 8'h02;
      BRC_OFF: return (w & 8'hBB) | 8'h40;
      DIVL_OFF, DIVH_OFF: return w;
      default: return 8'h00;
    endcase
  endfunction

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Waits for hready (0), a baud tick (1) or a wake event (2); dur gets the edges spent
  task automatic till(input int k, input int lim);
    int n;
    @(posedge clk);
    for (n = 0; n < lim && (k == 0 ? hreadyout : k == 1 ? baud_tick : wake_event) !== 1'b1; n++)
      @(posedge clk);
    dur = n + 1;
    if (n >= lim)
    begin
      err_total++;
      tally_and_finish();
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    till(0, 50);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    till(0, 50);
    q = hrdata[7:0];
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk({24'h0, q}, {24'h0, e});
  endtask

  task automatic pulse(input int i);
    dp[i] <= 1'b1;
    @(posedge clk);
    dp[i] <= 1'b0;
    @(posedge clk);
  endtask

  initial
  begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 6; i++)
      rdc(offs[i], rb(offs[i], 8'h00));
    for (int i = 0; i < 5; i++)
    begin
      lf = nx(lf);
      bus(1'b1, offs[i], lf[7:0]);
      rdc(offs[i], rb(offs[i], lf[7:0]));
      bus(1'b1, offs[i], 8'h00);
    end
    bus(1'b1, RSC_OFF, 8'h90);
    bus(1'b1, TSC_OFF, 8'h08);
    pulse(0);
    rdc(TSC_OFF, 8'h08);
    pulse(1);
    pulse(2);
    rdc(TSC_OFF, 8'h02);
    // Async with the port enabled: the transmit pin is driven with the true line level
    chk({31'h0, tx_ck_oe_n}, 32'h0);
    chk({31'h0, tx_ck_o}, {31'h0, lf[3]});
    pulse(3);
    rdc(BRC_OFF, 8'h00);
    pulse(4);
    pulse(5);
    rdc(RSC_OFF, 8'h92);
    bus(1'b1, RSC_OFF, 8'h80);
    rdc(RSC_OFF, 8'h80);
    rdc(BRC_OFF, 8'h40);
    bus(1'b1, RSC_OFF, 8'hD8);
    for (int b = 0; b < 2; b++)
    begin
      @(posedge clk);
      bit8 <= b[0];
      stop_ok <= ~b[0];
      dp[4] <= 1'b1;
      #5;
      chk({31'h0, rx_accept}, {31'h0, b[0]});
      @(posedge clk);
      dp[4] <= 1'b0;
    end
    rdc(RSC_OFF, 8'hDD);
    bus(1'b1, RSC_OFF, 8'h80);
    bus(1'b1, DIVH_OFF, 8'h01);
    // Second interval is measured: the first one after a restart lasts only one prescaler period
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b1, TSC_OFF, tv[i]);
      bus(1'b1, BRC_OFF, bv[i]);
      bus(1'b1, DIVL_OFF, 8'h02);
      till(1, 9000);
      till(1, 9000);
      chk(32'(dur), 32'(per[i]));
    end
    bus(1'b1, TSC_OFF, 8'h00);
    bus(1'b1, RSC_OFF, 8'h90);
    bus(1'b1, BRC_OFF, 8'h01);
    u_node.send(8'h55, 288);
    rdc(BRC_OFF, 8'h40);
    rdc(DIVL_OFF, 8'h03);
    rdc(DIVH_OFF, 8'h00);
    bus(1'b1, BRC_OFF, 8'h02);
    fork
      u_node.send(8'h00, 40);
      till(2, 2000);
    join
    rdc(BRC_OFF, 8'h40);
    tally_and_finish();
  end
endmodule  // serial_port_ctrl_tb
